/* File: hw/odl_cfg.svh */
`ifndef ODL_CFG_SVH
`define ODL_CFG_SVH

// Word layout
`define ODL_WORD_BITS 11
`define ODL_ADDR_BITS 3
`define ODL_VALUE_BITS 8
`define ODL_CHANNELS 8
`define ODL_ADDR_POS 8
`define ODL_ADDR_TOP 10
`define ODL_VALUE_POS 0
`define ODL_VALUE_TOP 7
`define ODL_LONG_BITS 16

// Reset values
`define ODL_MIDSCALE 8'h80
`define ODL_SHIFT_RESET 11'h000

// Timing, host clock 125 MHz
`define ODL_CLK_NS 8
`define ODL_SCLK_HALF_NS 80
`define ODL_CS_SETUP_NS 10
`define ODL_CS_HOLD_NS 15
`define ODL_CS_GAP_NS 10
`define ODL_SCLK_HALF_CYC ((`ODL_SCLK_HALF_NS + `ODL_CLK_NS - 1) / `ODL_CLK_NS)
`define ODL_CS_SETUP_CYC ((`ODL_CS_SETUP_NS + `ODL_CLK_NS - 1) / `ODL_CLK_NS)
`define ODL_CS_HOLD_CYC ((`ODL_CS_HOLD_NS + `ODL_CLK_NS - 1) / `ODL_CLK_NS)
`define ODL_CS_GAP_CYC ((`ODL_CS_GAP_NS + `ODL_CLK_NS - 1) / `ODL_CLK_NS)

`endif

/* File: hw/odl_pkg.sv */
`include "odl_cfg.svh"

package odl_pkg;
    typedef logic [`ODL_ADDR_BITS-1:0] odl_addr_t;
    typedef logic [`ODL_VALUE_BITS-1:0] odl_value_t;
    typedef logic [`ODL_WORD_BITS-1:0] odl_word_t;
    typedef logic [`ODL_LONG_BITS-1:0] odl_frame_t;
    typedef logic [`ODL_CHANNELS-1:0] odl_chan_mask_t;
    typedef logic [`ODL_CHANNELS-1:0][`ODL_VALUE_BITS-1:0] odl_bank_t;
    typedef logic [7:0] odl_timer_t;
    typedef logic [4:0] odl_count_t;

    typedef enum logic [2:0] {
        ODL_IDLE = 3'h0,
        ODL_SETUP = 3'h1,
        ODL_LOW = 3'h3,
        ODL_HIGH = 3'h2,
        ODL_HOLD = 3'h6,
        ODL_GAP = 3'h4
    } odl_state_t;

    function automatic odl_word_t odl_pack(input odl_addr_t addr, input odl_value_t value);
        odl_pack = {addr, value};
    endfunction
endpackage

/* File: hw/odl_link_if.sv */
`timescale 1ns/1ps

interface odl_link_if;
    logic sclk;
    logic select_n;
    logic serial_in;

    modport ctl (
        output sclk,
        output select_n,
        output serial_in
    );

    modport dac (
        input sclk,
        input select_n,
        input serial_in
    );
endinterface

/* File: hw/odl_dac_dev.sv */
// What this block does
// - Shift on rising clock only while selected
// - Select rising edge loads addressed latch
// - Last eleven shifted bits form the command
// - Decoder enables exactly one latch
// - Latch takes final eight data bits only
// - Controller sends one framed word per channel
// - Excess early bits fall off the top
// - Word is three address, eight value bits
// - Controller lowers select before clocking
// - Clock held high when select rises
// - Address value plus one names channel
// - Most significant bit shifted first
// - Power-on sets every latch mid-scale
// - Shutdown keeps all latch values

`timescale 1ns/1ps

`include "odl_cfg.svh"

module odl_dac_dev
    import odl_pkg::*;
(
    odl_link_if.dac LINK,
    input wire logic RESETN,
    input wire logic MIDSCALE_RESET_N,
    input wire logic POWER_DOWN_N,
    output odl_bank_t CHANNEL_OUTPUT,
    output logic OUTPUT_ACTIVE,
    output odl_word_t LAST_WORD,
    output logic UPDATE_TOGGLE,
    output odl_chan_mask_t WRITTEN
);

    odl_word_t shift;
    odl_word_t next_shift;
    odl_addr_t addr_field;
    odl_value_t value_field;
    odl_chan_mask_t enable;
    wire odl_value_t latch [`ODL_CHANNELS];
    logic load_rst_n;
    logic toggle;
    odl_word_t word;
    wire odl_chan_mask_t written;

    // Serial register
    // Only the newest eleven bits are kept; anything older simply
    // falls off the top, so a 16-bit frame needs no special case.
    always_comb begin
        next_shift = {shift[`ODL_WORD_BITS-2:0], LINK.serial_in};
    end

    // The register runs on the link clock and sees select as a
    // level; the controller lowers select before the first edge.
    always_ff @(posedge LINK.sclk or negedge RESETN) begin
        if (!RESETN) begin
            shift <= `ODL_SHIFT_RESET;
        end else if (!LINK.select_n) begin
            shift <= next_shift;
        end
    end

    // Field split of the held word
    always_comb begin
        addr_field = shift[`ODL_ADDR_TOP:`ODL_ADDR_POS];
        value_field = shift[`ODL_VALUE_TOP:`ODL_VALUE_POS];
    end

    // Address decoder
    // Index i drives channel i+1, so address 0 is the first output.
    always_comb begin
        enable = '0;
        for (int i = 0; i < `ODL_CHANNELS; i++) begin
            if (addr_field == odl_addr_t'(i)) begin
                enable[i] = 1'b1;
            end
        end
    end

    // Latch bank
    // Both resets act without any clock edge, since the link clock
    // may stand still; the reset input is combined with power-on.
    always_comb begin
        load_rst_n = RESETN & MIDSCALE_RESET_N;
    end

    // Latches are clocked by the select rising edge. The serial
    // register is stable then because the clock is already high
    // and no further rising edge can arrive before select drops.
    odl_chan_reg chan0_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[0]),
        .value(value_field),
        .level(latch[0]),
        .written(written[0])
    );

    odl_chan_reg chan1_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[1]),
        .value(value_field),
        .level(latch[1]),
        .written(written[1])
    );

    odl_chan_reg chan2_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[2]),
        .value(value_field),
        .level(latch[2]),
        .written(written[2])
    );

    odl_chan_reg chan3_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[3]),
        .value(value_field),
        .level(latch[3]),
        .written(written[3])
    );

    odl_chan_reg chan4_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[4]),
        .value(value_field),
        .level(latch[4]),
        .written(written[4])
    );

    odl_chan_reg chan5_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[5]),
        .value(value_field),
        .level(latch[5]),
        .written(written[5])
    );

    odl_chan_reg chan6_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[6]),
        .value(value_field),
        .level(latch[6]),
        .written(written[6])
    );

    odl_chan_reg chan7_i (
        .load_clk(LINK.select_n),
        .load_rst_n(load_rst_n),
        .load_en(enable[7]),
        .value(value_field),
        .level(latch[7]),
        .written(written[7])
    );

    // Update record
    // One toggle per completed frame lets a user clock domain see
    // each update through a plain two-flop synchroniser.
    always_ff @(posedge LINK.select_n or negedge RESETN) begin
        if (!RESETN) begin
            word <= `ODL_SHIFT_RESET;
        end else begin
            word <= shift;
        end
    end

    always_ff @(posedge LINK.select_n or negedge RESETN) begin
        if (!RESETN) begin
            toggle <= 1'b0;
        end else begin
            toggle <= ~toggle;
        end
    end

    // Output stage
    // No free-running clock exists here, so the shutdown level is
    // passed straight through rather than synchronised.
    always_comb begin
        OUTPUT_ACTIVE = POWER_DOWN_N;
        LAST_WORD = word;
        UPDATE_TOGGLE = toggle;
        WRITTEN = written;
        // Shutdown does not touch the latches; old codes return with it
        for (int i = 0; i < `ODL_CHANNELS; i++) begin
            CHANNEL_OUTPUT[i] = latch[i];
        end
    end

endmodule

// One channel register; the select rising edge is its only clock,
// so a stopped link clock never disturbs a stored code.
module odl_chan_reg
    import odl_pkg::*;
#(
    parameter odl_value_t RESET_LEVEL = `ODL_MIDSCALE
)
(
    input wire logic load_clk,
    input wire logic load_rst_n,
    input wire logic load_en,
    input wire odl_value_t value,
    output odl_value_t level,
    output logic written
);

    always_ff @(posedge load_clk or negedge load_rst_n) begin
        if (!load_rst_n) begin
            level <= RESET_LEVEL;
        end else if (load_en) begin
            level <= value;
        end
    end

    always_ff @(posedge load_clk or negedge load_rst_n) begin
        if (!load_rst_n) begin
            written <= 1'b0;
        end else if (load_en) begin
            written <= 1'b1;
        end
    end

endmodule

/* File: hw/odl_ctl_host.sv */
`timescale 1ns/1ps

`include "odl_cfg.svh"

module odl_ctl_host
    import odl_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    odl_link_if.ctl LINK,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire odl_addr_t REQ_ADDR,
    input wire odl_value_t REQ_VALUE,
    input wire logic REQ_LONG,
    output logic BUSY
);

    localparam odl_timer_t HALF_CYC = odl_timer_t'(`ODL_SCLK_HALF_CYC);
    localparam odl_timer_t SETUP_CYC = odl_timer_t'(`ODL_CS_SETUP_CYC);
    localparam odl_timer_t HOLD_CYC = odl_timer_t'(`ODL_CS_HOLD_CYC);
    localparam odl_timer_t GAP_CYC = odl_timer_t'(`ODL_CS_GAP_CYC);
    localparam odl_count_t SHORT_BITS = odl_count_t'(`ODL_WORD_BITS);
    localparam odl_count_t LONG_BITS = odl_count_t'(`ODL_LONG_BITS);

    odl_state_t state;
    odl_timer_t timer;
    odl_count_t bits_left;
    odl_frame_t frame;
    logic sclk;
    logic cs_n;
    logic sdo;
    logic start;
    logic done;
    logic bit_go;
    logic rise;

    always_comb begin
        REQ_READY = (state == ODL_IDLE);
        BUSY = (state != ODL_IDLE);
        start = REQ_VALID & REQ_READY;
        done = (timer == 8'h00);
        bit_go = done & ((state == ODL_SETUP) | ((state == ODL_HIGH) & (bits_left != 5'h00)));
        rise = done & (state == ODL_LOW);
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= ODL_IDLE;
            timer <= 8'h00;
        end else begin
            case (state)
                ODL_IDLE: begin
                    if (start) begin
                        state <= ODL_SETUP;
                        timer <= SETUP_CYC - 8'h01;
                    end
                end
                ODL_SETUP: begin
                    if (done) begin
                        state <= ODL_LOW;
                        timer <= HALF_CYC - 8'h01;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ODL_LOW: begin
                    if (done) begin
                        state <= ODL_HIGH;
                        timer <= HALF_CYC - 8'h01;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ODL_HIGH: begin
                    if (done && bits_left == 5'h00) begin
                        state <= ODL_HOLD;
                        timer <= HOLD_CYC - 8'h01;
                    end else if (done) begin
                        state <= ODL_LOW;
                        timer <= HALF_CYC - 8'h01;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ODL_HOLD: begin
                    if (done) begin
                        state <= ODL_GAP;
                        timer <= GAP_CYC - 8'h01;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                ODL_GAP: begin
                    if (done) begin
                        state <= ODL_IDLE;
                    end else begin
                        timer <= timer - 8'h01;
                    end
                end
                default: begin
                    state <= ODL_IDLE;
                    timer <= 8'h00;
                end
            endcase
        end
    end

    // Frame register; a long frame pads five zeros in front so the
    // last eleven bits still carry address then value.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            frame <= 16'h0000;
            bits_left <= 5'h00;
        end else if (start) begin
            frame <= REQ_LONG ? {5'h00, odl_pack(REQ_ADDR, REQ_VALUE)}
                              : {odl_pack(REQ_ADDR, REQ_VALUE), 5'h00};
            bits_left <= REQ_LONG ? LONG_BITS : SHORT_BITS;
        end else begin
            if (bit_go) begin
                frame <= {frame[`ODL_LONG_BITS-2:0], 1'b0};
            end
            if (rise) begin
                bits_left <= bits_left - 5'h01;
            end
        end
    end

    // Data changes on the falling clock half, giving the device a
    // full half period of setup and hold around each rising edge.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sclk <= 1'b1;
            cs_n <= 1'b1;
            sdo <= 1'b0;
        end else begin
            if (start) begin
                cs_n <= 1'b0;
            end else if (state == ODL_HOLD && done) begin
                cs_n <= 1'b1;
            end
            if (bit_go) begin
                sclk <= 1'b0;
                sdo <= frame[`ODL_LONG_BITS-1];
            end else if (rise) begin
                sclk <= 1'b1;
            end
        end
    end

    always_comb begin
        LINK.sclk = sclk;
        LINK.select_n = cs_n;
        LINK.serial_in = sdo;
    end

endmodule

/* File: dv/odl_link_monitor.sv */
`timescale 1ns/1ps

module odl_link_monitor (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic serial_in
);
    // Rises in the open frame; the link has no clock of its own to count on
    logic [4:0] rises;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rises <= 5'h00;
        end else if (select_n) begin
            rises <= 5'h00;
        end else if ($rose(sclk)) begin
            rises <= rises + 5'h01;
        end
    end

    AST_IDLE_SCLK_HIGH: assert property (@(posedge CLK) disable iff (!RESETN) select_n |-> sclk)
        else $error("sclk low while deselected");
    AST_END_SCLK_HIGH: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(select_n) |-> sclk && $past(sclk, 8)) else $error("sclk not high at select rise");
    AST_SETUP: assert property (@(posedge CLK) disable iff (!RESETN) $fell(select_n) |-> sclk [*2])
        else $error("clocking began too soon after select");
    AST_HIGH_HALF: assert property (@(posedge CLK) disable iff (!RESETN) $rose(sclk) |-> sclk [*8])
        else $error("sclk high phase short");
    AST_LOW_HALF: assert property (@(posedge CLK) disable iff (!RESETN) $fell(sclk) |-> !sclk [*8])
        else $error("sclk low phase short");
    AST_DATA_STABLE: assert property (@(posedge CLK) disable iff (!RESETN)
        sclk && !select_n |-> $stable(serial_in)) else $error("data moved while sclk high");
    AST_FRAME_BITS: assert property (@(posedge CLK) disable iff (!RESETN)
        $rose(select_n) |-> rises == 5'h0B || rises == 5'h10) else $error("frame bit count wrong");
    AST_GAP: assert property (@(posedge CLK) disable iff (!RESETN) $rose(select_n) |-> select_n [*2])
        else $error("select high gap short");
endmodule

/* File: dv/octal_dac_serial_loader_tb.sv */
`timescale 1ns/1ps

module octal_dac_serial_loader_tb;
    import odl_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b1;
    logic req_valid = 1'b0;
    logic req_long = 1'b0;
    logic mid_n = 1'b1;
    logic pd_n = 1'b1;
    odl_addr_t req_addr = '0;
    odl_value_t req_value = '0;
    logic req_ready, busy, active, upd;
    odl_bank_t chan, exp_bank;
    odl_word_t last_word, nt;
    odl_chan_mask_t written;
    odl_frame_t cap;
    odl_word_t notes[$];
    int n_errors = 0;
    int total_checks = 0;

    odl_link_if link();
    odl_ctl_host odl_ctl_host_i (.CLK(clk), .RESETN(resetn), .LINK(link.ctl), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ_ADDR(req_addr), .REQ_VALUE(req_value), .REQ_LONG(req_long), .BUSY(busy));
    odl_dac_dev odl_dac_dev_i (.LINK(link.dac), .RESETN(resetn), .MIDSCALE_RESET_N(mid_n),
        .POWER_DOWN_N(pd_n), .CHANNEL_OUTPUT(chan), .OUTPUT_ACTIVE(active), .LAST_WORD(last_word),
        .UPDATE_TOGGLE(upd), .WRITTEN(written));
    odl_link_monitor odl_link_monitor_i (.CLK(clk), .RESETN(resetn), .sclk(link.sclk),
        .select_n(link.select_n), .serial_in(link.serial_in));

    initial begin
        forever #4 clk = ~clk;
    end

    task automatic chk_word(input odl_frame_t got, input odl_frame_t exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bank(input odl_bank_t got, input odl_bank_t exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_mask(input odl_chan_mask_t got, input odl_chan_mask_t exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic send(input odl_addr_t a, input odl_value_t v, input logic l);
        int n;
        n = 0;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        if (req_ready !== 1'b1) begin
            n_errors++;
        end
        req_addr = a;
        req_value = v;
        req_long = l;
        req_valid = 1'b1;
        notes.push_back({a, v});
        @(negedge clk);
        req_valid = 1'b0;
        chk_bit(busy, 1'b1);
    endtask

    task automatic drain;
        for (int n = 0; n < 1000 && (notes.size() != 0 || req_ready !== 1'b1); n++) begin
            @(negedge clk);
        end
        if (notes.size() != 0 || req_ready !== 1'b1) begin
            n_errors++;
        end
    endtask

    // Wire capture, cleared per frame so a short frame leaves the top five bits zero
    initial begin
        cap = '0;
        forever begin
            @(negedge link.select_n);
            cap = '0;
            while (link.select_n === 1'b0) begin
                @(posedge link.sclk or posedge link.select_n);
                if (link.select_n === 1'b0) begin
                    cap = {cap[14:0], link.serial_in};
                end
            end
        end
    end

    always @(upd) begin
        if (resetn === 1'b1) begin
            #1;
            if (notes.size() == 0) begin
                chk_bit(1'b1, 1'b0);
            end else begin
                nt = notes.pop_front();
                exp_bank[nt[10:8]] = nt[7:0];
                chk_word(odl_frame_t'(last_word), odl_frame_t'(nt));
                chk_word(cap, odl_frame_t'(nt));
                chk_bank(chan, exp_bank);
            end
        end
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        test_done;
    end

    initial begin
        void'($urandom(93861));
        exp_bank = {8{8'h80}};
        // Reset falls after time zero so every reset branch sees an edge
        #1;
        resetn = 1'b0;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        chk_bank(chan, exp_bank);
        chk_mask(written, 8'h00);
        for (int i = 0; i < 8; i++) begin
            send(odl_addr_t'(i), odl_value_t'($urandom), i[0]);
        end
        drain;
        chk_mask(written, 8'hFF);
        pd_n = 1'b0;
        repeat (4) @(negedge clk);
        chk_bit(active, 1'b0);
        chk_bank(chan, exp_bank);
        pd_n = 1'b1;
        @(negedge clk);
        chk_bit(active, 1'b1);
        chk_bank(chan, exp_bank);
        send(3'h3, 8'h00, 1'b1);
        send(3'h3, 8'hFF, 1'b0);
        drain;
        mid_n = 1'b0;
        exp_bank = {8{8'h80}};
        @(negedge clk);
        chk_bank(chan, exp_bank);
        chk_mask(written, 8'h00);
        mid_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            send(odl_addr_t'($urandom), odl_value_t'($urandom), 1'($urandom));
        end
        drain;
        // Second reset in mid-run: latches must fall back to mid-scale
        resetn = 1'b0;
        exp_bank = {8{8'h80}};
        @(negedge clk);
        chk_bank(chan, exp_bank);
        chk_word(odl_frame_t'(last_word), 16'h0000);
        chk_mask(written, 8'h00);
        resetn = 1'b1;
        send(3'h5, odl_value_t'($urandom), 1'b0);
        drain;
        test_done;
    end
endmodule
